// ===== hdl/timer16.sv
// Sixteen-bit down-counting timer with reload latch, four modes and
// a prescale stage as an optional count source.
// Assumes a byte register port on the system clock; the counter pin is
// asynchronous and is synchronised here.
//
// Operation
// - Prescale write loads latch, counter unless deferred
// - Output bit low stops prescale stage and clock
// - Counter counts down, reloads after reaching zero
// - Underflow sets the timer interrupt flag
// - Reload n gives underflow every n+1 pulses
// - Two-bit field selects one of four modes
// - Low byte held, high byte commits both
// - Load-write bit chooses immediate or deferred load
// - High read snapshots the low byte for low read
// - Internal source: divided clock or prescaled clock
// - Pulse output toggles pin, polarity sets start
// - Width mode counts at active level, interrupts
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module timer16
  import timer_pkg::*;
#(
  parameter int CWIDTH = 16
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic [7:0]      rdata_out,
  // Counter pin (two-way)
  input  wire logic       counter_pin_in,
  output logic            counter_pin_out,
  output logic            counter_pin_oe_out,
  // Prescaled clock for serial blocks, and interrupt
  output logic            prescaled_clock_out,
  output logic            irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [CWIDTH-1:0]    count_reg, count_next;
  logic [CWIDTH-1:0]    reload_reg, reload_next;
  logic [7:0]           wr_low_reg, wr_low_next;
  logic [7:0]           rd_low_reg, rd_low_next;
  logic [7:0]           mode_reg, mode_next;
  logic [7:0]           pmode_reg, pmode_next;
  logic [2:0]           status_reg, status_next;
  logic [2:0]           mask_reg, mask_next;
  logic [7:0]           rdata_reg, rdata_next;
  logic                 pin_reg, pin_next;
  logic                 oe_reg, oe_next;
  logic                 irq_reg, irq_next;
  logic                 pclk_reg;
  logic [DIV_WIDTH-1:0] div_reg;
  logic                 sync1_reg, sync2_reg, sync3_reg;
  logic                 stage_tick;
  logic [7:0]           stage_latch;

  // Decoded control fields
  timer_mode_t mode;
  logic        polarity, stop, use_prescale, load_only;
  assign mode         = timer_mode_t'(mode_reg[BIT_MODE_LO +: 2]);
  assign polarity     = mode_reg[BIT_POLARITY];
  assign stop         = mode_reg[BIT_COUNT_STOP];
  assign use_prescale = mode_reg[BIT_CLK_SELECT];
  assign load_only    = mode_reg[BIT_LOAD_WRITE];

  // Byte-lane write decode used by several registers
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs, input logic w);
    return w && (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Clock divider and pin synchroniser
  // ----------------------------------------------------------------
  // Free-running divider; enables are one-cycle pulses, never clocks
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_reg   <= '0;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      div_reg   <= div_reg + 1'b1;
      sync1_reg <= counter_pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Divided-clock enable: low 3..6 bits all ones
  logic [1:0] div_sel;
  logic       div_tick;
  assign div_sel  = mode_reg[BIT_DIV_LO +: 2];
  always_comb begin
    case (div_sel)
      2'h0:    div_tick = &div_reg[DIV_BASE_LOG2-1:0];
      2'h1:    div_tick = &div_reg[DIV_BASE_LOG2:0];
      2'h2:    div_tick = &div_reg[DIV_BASE_LOG2+1:0];
      default: div_tick = &div_reg[DIV_BASE_LOG2+2:0];
    endcase
  end

  // Second prescale stage, clocked every system clock
  prescale_stage #(.WIDTH(8)) u_stage (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .count_in      (1'b1),
    .enable_in     (pmode_reg[BIT_PRESCALE_OUT]),
    .latch_only_in (pmode_reg[BIT_STAGE_TWO_WR]),
    .write_in      (wr_hit(addr_in, OFS_STAGE_TWO, wr_in)),
    .wdata_in      (wdata_in),
    .tick_out      (stage_tick),
    .latch_out     (stage_latch)
  );

  // ----------------------------------------------------------------
  // Count source selection
  // ----------------------------------------------------------------
  logic internal_tick, pin_rise, pin_fall, edge_tick, pin_active, count_pulse;
  // A stage tick already in flight when the output bit drops must not reach the timer
  assign internal_tick = use_prescale ? (stage_tick & pmode_reg[BIT_PRESCALE_OUT]) : div_tick;
  assign pin_rise      = sync2_reg & ~sync3_reg;
  assign pin_fall      = ~sync2_reg & sync3_reg;
  assign edge_tick     = polarity ? pin_fall : pin_rise;
  assign pin_active    = polarity ? ~sync2_reg : sync2_reg;

  // Timer and pulse-output modes share the internal tick, event and width modes pick their own; stop gates all of them
  always_comb begin
    case (mode)
      MODE_EVENT: count_pulse = edge_tick;
      MODE_WIDTH: count_pulse = internal_tick && pin_active;
      default:    count_pulse = internal_tick;
    endcase
    if (stop) begin
      count_pulse = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Counter, latches, registers, interrupt
  // ----------------------------------------------------------------
  logic underflow, width_done, commit;
  assign underflow  = count_pulse && (count_reg == '0);
  assign width_done = (mode == MODE_WIDTH) && (polarity ? pin_rise : pin_fall);
  assign commit     = wr_hit(addr_in, OFS_COUNT_HIGH, wr_in);

  always_comb begin
    count_next  = count_reg;
    reload_next = reload_reg;
    wr_low_next = wr_low_reg;
    rd_low_next = rd_low_reg;
    mode_next   = mode_reg;
    pmode_next  = pmode_reg;
    mask_next   = mask_reg;
    status_next = status_reg;
    pin_next    = pin_reg;
    oe_next     = (mode == MODE_PULSE_OUT);
    rdata_next  = 8'h00;
    // Count down, reload from latch after zero
    if (underflow) begin
      count_next = reload_reg;
    end else if (count_pulse) begin
      count_next = count_reg - 1'b1;
    end
    // Low byte parks in the holding register until the high byte arrives
    if (wr_hit(addr_in, OFS_COUNT_LOW, wr_in)) begin
      wr_low_next = wdata_in;
    end
    if (commit) begin
      reload_next = {wdata_in, wr_low_reg};
      if (!load_only || underflow) begin
        count_next = {wdata_in, wr_low_reg};
      end
    end
    if (wr_hit(addr_in, OFS_MODE_CONTROL, wr_in)) begin
      mode_next = wdata_in;
      // Pulse output starts at the level opposite the polarity bit
      pin_next  = ~wdata_in[BIT_POLARITY];
    end
    if (wr_hit(addr_in, OFS_PRESCALE_MODE, wr_in)) begin
      pmode_next = {4'h0, wdata_in[3:0]};
    end
    if (wr_hit(addr_in, OFS_IRQ_MASK, wr_in)) begin
      mask_next = wdata_in[2:0];
    end
    if (wr_hit(addr_in, OFS_IRQ_STATUS, wr_in)) begin
      status_next = status_next & ~wdata_in[2:0];
    end
    if (underflow && mode == MODE_PULSE_OUT) begin
      pin_next = ~pin_reg;
    end
    // Set wins over a simultaneous clear
    status_next[IRQ_UNDERFLOW] = status_next[IRQ_UNDERFLOW] | underflow;
    status_next[IRQ_WIDTH]     = status_next[IRQ_WIDTH] | width_done;
    status_next[IRQ_PULSE_DONE] = status_next[IRQ_PULSE_DONE] | stage_tick;
    // Read path; high read snapshots the low byte for the next low read
    if (rd_in) begin
      case (addr_in)
        OFS_COUNT_HIGH: begin
          rdata_next  = count_reg[15:8];
          rd_low_next = count_reg[7:0];
        end
        OFS_COUNT_LOW:     rdata_next = rd_low_reg;
        OFS_MODE_CONTROL:  rdata_next = mode_reg;
        OFS_STAGE_TWO:     rdata_next = stage_latch;
        OFS_PRESCALE_MODE: rdata_next = pmode_reg;
        OFS_IRQ_STATUS:    rdata_next = {5'h00, status_reg};
        OFS_IRQ_MASK:      rdata_next = {5'h00, mask_reg};
        default:           rdata_next = 8'h00;
      endcase
    end
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_reg  <= {RST_COUNT_BYTE, RST_COUNT_BYTE};
      reload_reg <= {RST_COUNT_BYTE, RST_COUNT_BYTE};
      wr_low_reg <= RST_COUNT_BYTE;
      rd_low_reg <= RST_COUNT_BYTE;
      mode_reg   <= RST_MODE;
      pmode_reg  <= RST_MODE;
      status_reg <= '0;
      mask_reg   <= '0;
      rdata_reg  <= 8'h00;
      pin_reg    <= 1'b1;
      oe_reg     <= 1'b0;
      irq_reg    <= 1'b0;
      pclk_reg   <= 1'b0;
    end else begin
      count_reg  <= count_next;
      reload_reg <= reload_next;
      wr_low_reg <= wr_low_next;
      rd_low_reg <= rd_low_next;
      mode_reg   <= mode_next;
      pmode_reg  <= pmode_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
      rdata_reg  <= rdata_next;
      pin_reg    <= pin_next;
      oe_reg     <= oe_next;
      irq_reg    <= irq_next;
      pclk_reg   <= stage_tick & pmode_reg[BIT_PRESCALE_OUT];
    end
  end

  assign rdata_out           = rdata_reg;
  assign counter_pin_out     = pin_reg;
  assign counter_pin_oe_out  = oe_reg;
  assign prescaled_clock_out = pclk_reg;
  assign irq_out             = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_underflow_reload;
    @(posedge clk_in) disable iff (!rstn_in)
      (underflow && !commit) |=> (count_reg == $past(reload_reg));
  endproperty
  a_underflow_reload: assert property (p_underflow_reload) else $error("no reload on underflow");

  property p_underflow_flag;
    @(posedge clk_in) disable iff (!rstn_in)
      underflow |=> status_reg[IRQ_UNDERFLOW];
  endproperty
  a_underflow_flag: assert property (p_underflow_flag) else $error("underflow flag not set");

  property p_stop_holds;
    @(posedge clk_in) disable iff (!rstn_in)
      (stop && !commit) |=> (count_reg == $past(count_reg));
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped");

  property p_commit_load;
    @(posedge clk_in) disable iff (!rstn_in)
      (commit && !load_only) |=> (count_reg == {$past(wdata_in), $past(wr_low_reg)});
  endproperty
  a_commit_load: assert property (p_commit_load) else $error("immediate load missed");

  property p_snapshot;
    @(posedge clk_in) disable iff (!rstn_in)
      (rd_in && addr_in == OFS_COUNT_HIGH) |=> (rd_low_reg == $past(count_reg[7:0]));
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("low byte not captured");

  property p_toggle;
    @(posedge clk_in) disable iff (!rstn_in)
      (underflow && mode == MODE_PULSE_OUT && !wr_in) |=> (pin_reg != $past(pin_reg));
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle");

  property p_width_gate;
    @(posedge clk_in) disable iff (!rstn_in)
      (mode == MODE_WIDTH && !pin_active && !commit) |=> (count_reg == $past(count_reg));
  endproperty
  a_width_gate: assert property (p_width_gate) else $error("counted at inactive level");

  property p_prescale_off;
    @(posedge clk_in) disable iff (!rstn_in)
      !pmode_reg[BIT_PRESCALE_OUT] |=> !prescaled_clock_out;
  endproperty
  a_prescale_off: assert property (p_prescale_off) else $error("prescaled clock not gated");

endmodule

// ===== include/timer_pkg.sv
// Constants shared by the 16-bit timer and its prescale stage.
// Assumes a single 50 MHz system clock and a byte-wide register port.
package timer_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_COUNT_LOW      = 8'h20;
  localparam logic [7:0] OFS_COUNT_HIGH     = 8'h21;
  localparam logic [7:0] OFS_MODE_CONTROL   = 8'h27;
  localparam logic [7:0] OFS_STAGE_TWO      = 8'h2e;
  localparam logic [7:0] OFS_PRESCALE_MODE  = 8'h2f;
  localparam logic [7:0] OFS_IRQ_STATUS     = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK       = 8'h31;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_COUNT_BYTE     = 8'hff;
  localparam logic [7:0] RST_MODE           = 8'h00;
  localparam logic [7:0] RST_STAGE_TWO      = 8'hff;

  // ----------------------------------------------------------------
  // Field positions in the mode control register
  // ----------------------------------------------------------------
  localparam int BIT_LOAD_WRITE   = 0;
  localparam int BIT_DIV_LO       = 1;
  localparam int BIT_CLK_SELECT   = 3;
  localparam int BIT_MODE_LO      = 4;
  localparam int BIT_POLARITY     = 6;
  localparam int BIT_COUNT_STOP   = 7;

  // Field positions in the prescaler mode control register
  localparam int BIT_STAGE_TWO_WR = 2;
  localparam int BIT_PRESCALE_OUT = 3;

  // Interrupt status bits
  localparam int IRQ_UNDERFLOW    = 0;
  localparam int IRQ_PULSE_DONE   = 1;
  localparam int IRQ_WIDTH        = 2;

  // Divider timing: system clock divided by 8, 16, 32 or 64
  localparam int DIV_BASE_LOG2    = 3;
  localparam int DIV_WIDTH        = 6;

  typedef enum logic [1:0] {
    MODE_TIMER, MODE_PULSE_OUT, MODE_EVENT, MODE_WIDTH
  } timer_mode_t;

endpackage

// ===== hdl/prescale_stage.sv
// Second prescale stage: 8-bit down counter with reload latch.
// Assumes count_in is a one-cycle enable on the system clock.
`timescale 1ns/1ns
module prescale_stage
  import timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  // Control
  input  wire logic             count_in,
  input  wire logic             enable_in,
  input  wire logic             latch_only_in,
  input  wire logic             write_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  // Output
  output logic                  tick_out,
  output logic [WIDTH-1:0]      latch_out
);

  logic [WIDTH-1:0] count_reg, count_next;
  logic [WIDTH-1:0] latch_reg, latch_next;
  logic             tick_reg, tick_next;

  // Next state: a write loads the latch, and the counter when not latch-only
  always_comb begin
    count_next = count_reg;
    latch_next = latch_reg;
    tick_next  = 1'b0;
    if (enable_in && count_in) begin
      if (count_reg == '0) begin
        count_next = latch_reg;
        tick_next  = 1'b1;
      end else begin
        count_next = count_reg - 1'b1;
      end
    end
    if (write_in) begin
      latch_next = wdata_in;
      if (!latch_only_in) begin
        count_next = wdata_in;
      end else if (enable_in && count_in && count_reg == '0) begin
        count_next = wdata_in;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_reg <= RST_STAGE_TWO;
      latch_reg <= RST_STAGE_TWO;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      latch_reg <= latch_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick_out  = tick_reg;
  assign latch_out = latch_reg;

endmodule

// ===== verif/pin_source.sv
// Counter pin partner: an outside signal source that sends a burst of pulses.
// Assumes the bench raises start_in for one cycle with the burst settings held.
`timescale 1ns/1ns
module pin_source (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Burst request
  input  wire logic        start_in,
  input  wire logic [7:0]  pulses_in,
  input  wire logic [15:0] width_in,
  input  wire logic        idle_in,
  // Timer drive of the shared wire
  input  wire logic        dut_level_in,
  input  wire logic        dut_oe_in,
  // Resolved wire level
  output logic             pin_out
);
  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  logic [8:0]  phase_reg;
  logic [15:0] tick_reg;

  // Each pulse is an idle span then an active span, width_in cycles each
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase_reg <= '0;
      tick_reg  <= '0;
    end else if (start_in) begin
      phase_reg <= {pulses_in, 1'b0};
      tick_reg  <= '0;
    end else if (phase_reg != '0) begin
      if (tick_reg == width_in - 16'h0001) begin
        tick_reg  <= '0;
        phase_reg <= phase_reg - 9'h001;
      end else begin
        tick_reg <= tick_reg + 16'h0001;
      end
    end
  end

  // Odd phases are active; the timer owns the wire while it drives it
  assign pin_out = dut_oe_in ? dut_level_in : (idle_in ^ phase_reg[0]);
endmodule

// ===== verif/sixteen_bit_timer_with_prescaler_test.sv
// Self-checking bench for the 16-bit timer and its prescale stage.
// Assumes the register port of timer16 and a pin_source partner on the pin.
`timescale 1ns/1ns
module sixteen_bit_timer_with_prescaler_test
  import timer_pkg::*;
;
  logic        clk_in;
  logic        rstn_in;
  logic        wr_en;
  logic        rd_en;
  logic        start;
  logic        idle;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  pulses;
  logic [15:0] width;
  logic        pin_out;
  logic        oe;
  logic        pin_wire;
  logic        pclk;
  logic        irq;
  int          mismatches;
  int          num_checks;

  timer16 dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_en),
    .rd_in(rd_en), .rdata_out(rdata), .counter_pin_in(pin_wire), .counter_pin_out(pin_out),
    .counter_pin_oe_out(oe), .prescaled_clock_out(pclk), .irq_out(irq));
  pin_source partner (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(start), .pulses_in(pulses),
    .width_in(width), .idle_in(idle), .dut_level_in(pin_out), .dut_oe_in(oe), .pin_out(pin_wire));

  // ----------------------------------------------------------------
  // Clock, checks and bus tasks
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobes rise one edge after entry, so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_in);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wr16(input logic [15:0] v);
    wr(OFS_COUNT_LOW, v[7:0]);
    wr(OFS_COUNT_HIGH, v[15:8]);
  endtask

  task automatic rd16(output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(OFS_COUNT_HIGH, h);
    rd(OFS_COUNT_LOW, l);
    v = {h, l};
  endtask

  // Cycles until the next rise of the pin or the prescaled clock, bounded
  task automatic wait_rise(input logic is_pin, output int n);
    logic prev;
    #1;
    prev = is_pin ? pin_out : pclk;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk_in);
      #1;
      if ((is_pin ? pin_out : pclk) === 1'b1 && prev !== 1'b1) break;
      prev = is_pin ? pin_out : pclk;
    end
    if (n == 2000) begin
      mismatches++;
      $display("BAD at %0t: edge never came", $time);
      final_report();
    end
  endtask

  task automatic burst(input logic [7:0] p, input logic [15:0] w);
    @(posedge clk_in);
    pulses <= p;
    width  <= w;
    start  <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    repeat (2 * p * w + 8) @(posedge clk_in);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] v;
    logic [7:0]  b;
    logic        seen;
    int          n;
    {rstn_in, wr_en, rd_en, start, idle} = '0;
    {addr, wdata, pulses} = '0;
    width = 16'h0004;
    mismatches = 0;
    num_checks = 0;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    // Reset values, an unmapped place and unstored prescaler bits
    rd16(v);
    check(v, {RST_COUNT_BYTE, RST_COUNT_BYTE});
    rd(OFS_MODE_CONTROL, b);
    check(b, RST_MODE);
    rd(OFS_PRESCALE_MODE, b);
    check(b, 8'h00);
    rd(8'h40, b);
    check(b, 8'h00);
    wr(OFS_PRESCALE_MODE, 8'hff);
    rd(OFS_PRESCALE_MODE, b);
    check(b, 8'h0f);
    wr(OFS_PRESCALE_MODE, 8'h00);
    // Stopped counter: immediate load, deferred load, no counting
    wr(OFS_MODE_CONTROL, 8'h80);
    wr16(16'h0002);
    rd16(v);
    check(v, 16'h0002);
    wr(OFS_MODE_CONTROL, 8'h81);
    wr16(16'h0005);
    repeat (100) @(posedge clk_in);
    rd16(v);
    check(v, 16'h0002);
    // Deferred reload 5 takes over at underflow: pin period 2*6*8
    wr(OFS_MODE_CONTROL, 8'h11);
    wait_rise(1'b1, n);
    wait_rise(1'b1, n);
    check(16'(n + 1), 16'd96);
    // Every division ratio with reload 3
    for (int d = 0; d < 4; d++) begin
      wr(OFS_MODE_CONTROL, 8'h90 | 8'(d << 1));
      wr16(16'h0003);
      wr(OFS_MODE_CONTROL, 8'h10 | 8'(d << 1));
      wait_rise(1'b1, n);
      wait_rise(1'b1, n);
      check(16'(n + 1), 16'(64 << d));
    end
    // Start level of the pulse output follows the polarity
    for (int p = 0; p < 2; p++) begin
      wr(OFS_MODE_CONTROL, 8'h90 | 8'(p << 6));
      repeat (2) @(posedge clk_in);
      #1;
      check({oe, pin_out}, {1'b1, ~p[0]});
    end
    // Timer mode releases the pin and flags underflows
    wr(OFS_MODE_CONTROL, 8'h00);
    wr(OFS_IRQ_STATUS, 8'hff);
    repeat (40) @(posedge clk_in);
    rd(OFS_IRQ_STATUS, b);
    check(b & 8'h01, 8'h01);
    check(oe, 1'b0);
    // Prescale stage: immediate then deferred reload
    wr(OFS_STAGE_TWO, 8'h04);
    rd(OFS_STAGE_TWO, b);
    check(b, 8'h04);
    wr(OFS_PRESCALE_MODE, 8'h08);
    wait_rise(1'b0, n);
    check(n < 8, 1'b1);
    wait_rise(1'b0, n);
    check(16'(n + 1), 16'd5);
    wr(OFS_PRESCALE_MODE, 8'h0c);
    // Step off the reload edge so an immediate load would show
    @(posedge clk_in);
    wr(OFS_STAGE_TWO, 8'h09);
    wait_rise(1'b0, n);
    check(n < 6, 1'b1);
    wait_rise(1'b0, n);
    check(16'(n + 1), 16'd10);
    // Timer on the prescaled clock: 2*2*10 cycles a pin period
    wr(OFS_MODE_CONTROL, 8'h98);
    wr16(16'h0001);
    wr(OFS_MODE_CONTROL, 8'h18);
    wait_rise(1'b1, n);
    wait_rise(1'b1, n);
    check(16'(n + 1), 16'd40);
    // Output bit low: no prescaled clock, so the timer halts too
    wr(OFS_PRESCALE_MODE, 8'h00);
    #1;
    b[0] = pin_out;
    seen = 1'b0;
    repeat (100) begin
      @(posedge clk_in);
      #1;
      seen = seen | pclk;
    end
    check({seen, pin_out}, {1'b0, b[0]});
    // Event counter from 2: underflow on the third rising edge
    wr(OFS_MODE_CONTROL, 8'h20);
    wr16(16'h0002);
    wr(OFS_IRQ_STATUS, 8'hff);
    wr(OFS_IRQ_MASK, 8'h01);
    burst(8'd2, 16'h0004);
    rd16(v);
    check({irq, v}, 17'h00000);
    burst(8'd1, 16'h0004);
    rd16(v);
    check({irq, v}, 17'h10002);
    wr(OFS_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk_in);
    check(irq, 1'b0);
    wr(OFS_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_in);
    check(irq, 1'b1);
    wr(OFS_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk_in);
    check(irq, 1'b0);
    // Width mode: an 80-cycle high pulse gives 10 counts at divide by 8
    wr(OFS_MODE_CONTROL, 8'h30);
    wr16(16'hffff);
    wr(OFS_IRQ_STATUS, 8'hff);
    burst(8'd1, 16'd80);
    rd16(v);
    check(v, 16'hfff5);
    rd(OFS_IRQ_STATUS, b);
    check(b, 8'h04);
    // Low-pulse width: idle high, a 40-cycle low pulse gives 5 counts
    wr(OFS_MODE_CONTROL, 8'h70);
    idle <= 1'b1;
    wr16(16'hffff);
    wr(OFS_IRQ_STATUS, 8'hff);
    burst(8'd1, 16'd40);
    rd16(v);
    check(v, 16'hfffa);
    rd(OFS_IRQ_STATUS, b);
    check(b, 8'h04);
    final_report();
  end
endmodule
